// *** logic/tocc_config.sv ***
// Configuration register low byte: expiry watch, overload response, frame check
// Assumes the serial front end gives cfg writes, power writes and transaction pulses
`timescale 1ns/10ps
`include "tocc_map.svh"
module tocc_config #(
	parameter int unsigned TICK_CYCLES  = `TOCC_TICK_MS * (`TOCC_CLK_HZ / 1000),
	parameter int unsigned RETRY_CYCLES = `TOCC_US_CYCLES(`TOCC_RETRY_PERIOD_US),
	parameter int unsigned ON_CYCLES    = `TOCC_US_CYCLES(`TOCC_RETRY_ON_US)
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire tocc_pkg::tocc_wr_t cfg_wr,
	input  wire tocc_pkg::tocc_wr_t pwr_wr,
	input  wire logic              flag_clear,
	input  wire logic              flag_enable,
	input  wire logic              xact_done,
	input  wire logic [3:0]        overload_in,
	output logic [15:0]            cfg_q,
	output logic [3:0]             channel_power_bits,
	output logic [3:0]             amp_on,
	output logic [3:0]             overload_flag,
	output logic                   expiry_flag,
	output logic                   soft_reset,
	output logic [5:0]             frame_bits,
	output logic                   crc_active,
	output logic                   int_n
);
	import tocc_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Timeout limit in ticks: code plus one
	function automatic logic [4:0] ticks_of(input logic [3:0] code);
		ticks_of = {1'b0, code} + 5'h01; // R01
	endfunction

	logic        watch_en;      // Expiry watch enable
	logic        action_rst;    // Expiry resets device
	logic        host_mode;     // Host-controlled overload
	logic [31:0] tick_cnt_q;    // Cycles within one 100ms tick
	logic [4:0]  tick_num_q;    // Ticks elapsed
	logic        expire;        // Expiry pulse
	logic [31:0] ret_cnt_q [4]; // Retry cycle counters
	tocc_ovl_t   ovl_st_q  [4]; // Overload state per channel

	assign watch_en   = cfg_q[`TOCC_WATCH_EN_BIT];
	assign action_rst = cfg_q[`TOCC_ACTION_BIT];
	assign host_mode  = cfg_q[`TOCC_RESP_SEL_BIT];
	assign crc_active = cfg_q[`TOCC_FRAME_CHECK_BIT]; // R09
	assign frame_bits = crc_active ? `TOCC_FRAME_LONG : `TOCC_FRAME_SHORT; // R09
	// Greater-or-equal so a shorter period written mid-count still expires at once
	assign expire     = clk_en && watch_en && !xact_done && tick_num_q >= ticks_of(cfg_q[7:4]); // R01
	assign int_n      = !(expiry_flag && flag_enable); // R11

	// ****************************************************************
	// Configuration register
	// ****************************************************************
	// Writes, plus partial reset on expiry with action one
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_q <= `TOCC_CFG_RESET; // R10
		end else if (clk_en) begin
			if (expire && action_rst) begin
				cfg_q <= (cfg_q & `TOCC_CFG_KEEP_MASK) | (`TOCC_CFG_RESET & ~`TOCC_CFG_KEEP_MASK); // R04
			end else if (cfg_wr.valid) begin
				cfg_q <= cfg_wr.data & `TOCC_CFG_WRITE_MASK;
			end
		end
	end

	// One-cycle soft reset to the rest of the device
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			soft_reset <= 1'b0;
		end else if (clk_en) begin
			soft_reset <= expire && action_rst; // R04
		end
	end

	// ****************************************************************
	// Expiry watch
	// ****************************************************************
	// Counts idle ticks; transactions restart it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 32'h0;
			tick_num_q <= 5'h00;
		end else if (clk_en) begin
			if (!watch_en || xact_done || expire) begin
				tick_cnt_q <= 32'h0; // R02 R12
				tick_num_q <= 5'h00;
			end else if (tick_cnt_q == TICK_CYCLES - 1) begin
				tick_cnt_q <= 32'h0;
				tick_num_q <= tick_num_q + 5'h01; // R01
			end else begin
				tick_cnt_q <= tick_cnt_q + 32'h1;
			end
		end
	end

	// Sticky expiry flag; set wins over clear, survives own reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			expiry_flag <= 1'b0;
		end else if (clk_en) begin
			if (expire) begin
				expiry_flag <= 1'b1; // R03 R04
			end else if (flag_clear) begin
				expiry_flag <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Overload handling per channel
	// ****************************************************************
	// Channel power bits: host write, overload clear in host mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			channel_power_bits <= 4'h0;
		end else if (clk_en) begin
			if (expire && action_rst) begin
				channel_power_bits <= 4'h0;
			end else begin
				for (int i = 0; i < 4; i++) begin
					if (host_mode && overload_in[i] && amp_on[i]) begin
						channel_power_bits[i] <= 1'b0; // R07
					end else if (pwr_wr.valid) begin
						channel_power_bits[i] <= pwr_wr.data[i]; // R08
					end
				end
			end
		end
	end

	// Amplifier state machine and overload flags
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				ovl_st_q[i]  <= TOCC_OK;
				ret_cnt_q[i] <= 32'h0;
			end
			overload_flag <= 4'h0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (overload_in[i] && amp_on[i]) begin
					overload_flag[i] <= 1'b1; // R05 R07
				end else if (expire && action_rst) begin
					overload_flag[i] <= 1'b0;
				end
				unique case (ovl_st_q[i])
					TOCC_OK: begin
						ret_cnt_q[i] <= 32'h0;
						if (overload_in[i] && channel_power_bits[i]) begin
							ovl_st_q[i] <= TOCC_OFF; // R05 R07
						end
					end
					TOCC_OFF: begin
						if (host_mode) begin
							if (channel_power_bits[i] && !overload_in[i]) begin
								ovl_st_q[i] <= TOCC_OK; // R08
							end
						end else if (ret_cnt_q[i] == RETRY_CYCLES - ON_CYCLES - 1) begin
							ret_cnt_q[i] <= 32'h0;
							ovl_st_q[i]  <= TOCC_RETRY; // R05
						end else begin
							ret_cnt_q[i] <= ret_cnt_q[i] + 32'h1;
						end
					end
					TOCC_RETRY: begin
						if (!overload_in[i]) begin
							ovl_st_q[i] <= TOCC_OK; // R06
						end else if (ret_cnt_q[i] == ON_CYCLES - 1) begin
							ret_cnt_q[i] <= 32'h0;
							ovl_st_q[i]  <= TOCC_OFF; // R05
						end else begin
							ret_cnt_q[i] <= ret_cnt_q[i] + 32'h1;
						end
					end
				endcase
			end
		end
	end

	// Amplifier power: powered channel not held off by overload
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			amp_on[i] = channel_power_bits[i] && ovl_st_q[i] != TOCC_OFF; // R05 R06
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	expiry_sets_flag_a: assert property (expire |=> expiry_flag) else $error("expiry flag missed"); // R03
	frame_len_a: assert property (frame_bits == (crc_active ? 6'd32 : 6'd24)) else $error("frame length"); // R09
	int_pin_a: assert property ((expiry_flag && flag_enable) == !int_n) else $error("interrupt pin"); // R11
	keep_frame_a: assert property (expire && action_rst |=> $stable(crc_active)) else $error("kept bit lost"); // R04
	reset_pulse_a: assert property (clk_en && expire && action_rst |=> soft_reset) else $error("no reset"); // R04
	no_act_a: assert property (clk_en && expire && !action_rst |=> !soft_reset) else $error("bad reset"); // R03
	idle_watch_a: assert property (!watch_en |-> !expire) else $error("watch off expired"); // R02
	xact_restart_a: assert property (clk_en && xact_done |=> tick_num_q == 5'h00) else $error("no restart"); // R12
	host_clear_a: assert property (clk_en && host_mode && overload_in[0] && amp_on[0] && !(expire && action_rst)
		|=> !channel_power_bits[0]) else $error("power bit kept"); // R07

	expire_c: cover property (expire);
	retry_c: cover property (ovl_st_q[0] == TOCC_RETRY);
	host_off_c: cover property (host_mode && ovl_st_q[1] == TOCC_OFF);
endmodule

// *** logic/tocc_map.svh ***
// Field positions, reset values and timing counts of the config block
// Assumes a 40 MHz mclk and a serial front end that reports register writes
//
// Overview of operation
// R01: Expiry period is 100ms times code plus one
// R02: Timeout runs only while watch enable set
// R03: Action zero: expiry only sets the flag
// R04: Action one: flag plus reset, keep listed bits
// R05: Auto mode: off, flag, retry 400us/8ms
// R06: Auto mode: overload gone leaves amplifier on
// R07: Host mode: off, flag, clear power bit
// R08: Host rewrites power bit to restart channel
// R09: Frame check on: 32-bit CRC frames, else 24
// R10: Frame check enable resets to one
// R11: Interrupt low when flag and enable set
// R12: Any completed transaction restarts timeout counter
`ifndef TOCC_MAP_SVH
`define TOCC_MAP_SVH
// ****************************************************************
// Field positions in device_configuration: low byte, plus the reference select at bit 8
// ****************************************************************
`define TOCC_FRAME_CHECK_BIT 0
`define TOCC_RESP_SEL_BIT    1
`define TOCC_WATCH_EN_BIT    2
`define TOCC_ACTION_BIT      3
`define TOCC_TSEL_LSB        4
`define TOCC_TSEL_MSB        7
`define TOCC_REF_SEL_BIT     8
// ****************************************************************
// Reset values
// ****************************************************************
`define TOCC_CFG_RESET       16'h0001
`define TOCC_CFG_KEEP_MASK   16'h0101
`define TOCC_CFG_WRITE_MASK  16'hFDFF
// ****************************************************************
// Timing
// ****************************************************************
`define TOCC_CLK_HZ          40000000
`define TOCC_TICK_MS         100
`define TOCC_RETRY_PERIOD_US 8000
`define TOCC_RETRY_ON_US     400
`define TOCC_US_CYCLES(us)   ((us) * (`TOCC_CLK_HZ / 1000000))
`define TOCC_FRAME_LONG      6'd32
`define TOCC_FRAME_SHORT     6'd24
`endif

// *** logic/tocc_pkg.sv ***
// Types shared by the timeout, overload and frame-check configuration block
// Assumes the map header is compiled alongside
package tocc_pkg;
	// Register write request from the serial front end
	typedef struct packed {
		logic        valid;  // One-cycle write strobe
		logic [15:0] data;   // Value written
	} tocc_wr_t;
	// Overload retry state per channel
	typedef enum logic [1:0] {TOCC_OK, TOCC_OFF, TOCC_RETRY} tocc_ovl_t;
endpackage

// *** testbench/tocc_host.sv ***
// SPI host stand-in: register writes and completed-transaction pulses
// Assumes the bench calls its tasks and shares mclk with the design
`timescale 1ns/10ps
module tocc_host (
	input  wire logic          mclk,
	output tocc_pkg::tocc_wr_t cfg_wr,
	output tocc_pkg::tocc_wr_t pwr_wr,
	output logic               xact_done
);
	import tocc_pkg::*;
	// Idle at time zero
	initial begin
		cfg_wr = '0;
		pwr_wr = '0;
		xact_done = 1'b0;
	end
	// Config write; data inverted once strobe drops
	// A register write is itself a completed transaction
	task automatic cfg(input logic [15:0] d);
		@(negedge mclk);
		cfg_wr    <= {1'b1, d};
		xact_done <= 1'b1;
		@(negedge mclk);
		cfg_wr    <= {1'b0, ~d};
		xact_done <= 1'b0;
	endtask
	// Power write; rewriting a cleared bit restarts a channel
	task automatic pwr(input logic [15:0] d);
		@(negedge mclk);
		pwr_wr    <= {1'b1, d};
		xact_done <= 1'b1;
		@(negedge mclk);
		pwr_wr    <= {1'b0, ~d};
		xact_done <= 1'b0;
	endtask
	// One completed serial transaction
	task automatic xact();
		@(negedge mclk) xact_done <= 1'b1;
		@(negedge mclk) xact_done <= 1'b0;
	endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the expiry, overload and frame-check config block
// Assumes short counts: tick 10, retry period 40, on time 4 cycles
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
	import tocc_pkg::*;
	logic mclk, rst, clk_en, flag_clear, flag_enable;
	logic [3:0] overload_in;
	tocc_wr_t cfg_wr, pwr_wr;
	logic xact_done, expiry_flag, soft_reset, crc_active, int_n;
	logic [15:0] cfg_q;
	logic [3:0] channel_power_bits, amp_on, overload_flag;
	logic [5:0] frame_bits;
	int fails = 0, samples_checked = 0, cyc = 0, n, cnt;
	// Rows: config value beside expected frame length
	logic [21:0] rows [5] = '{{16'h0004, 6'h18}, {16'h0035, 6'h20}, {16'h00F5, 6'h20},
		{16'h0001, 6'h20}, {16'h0000, 6'h18}};
	always #12.5 mclk = ~mclk;
	tocc_config #(.TICK_CYCLES(10), .RETRY_CYCLES(40), .ON_CYCLES(4)) tocc_config_inst (.mclk(mclk),
		.rst(rst), .clk_en(clk_en), .cfg_wr(cfg_wr), .pwr_wr(pwr_wr), .flag_clear(flag_clear),
		.flag_enable(flag_enable), .xact_done(xact_done), .overload_in(overload_in), .cfg_q(cfg_q),
		.channel_power_bits(channel_power_bits), .amp_on(amp_on), .overload_flag(overload_flag),
		.expiry_flag(expiry_flag), .soft_reset(soft_reset), .frame_bits(frame_bits),
		.crc_active(crc_active), .int_n(int_n));
	tocc_host tocc_host_inst (.mclk(mclk), .cfg_wr(cfg_wr), .pwr_wr(pwr_wr), .xact_done(xact_done));
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			stop_test();
		end
	end
	task automatic tick(input int k);
		repeat (k) @(negedge mclk);
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		// Idle levels and reset at time zero
		mclk = 1'b0;
		rst = 1'b1;
		clk_en = 1'b1;
		flag_clear = 1'b0;
		flag_enable = 1'b1;
		overload_in = 4'h0;
		tick(2);
		rst = 1'b0;
		`CHK("cfg_q", 16'h0001, cfg_q)
		`CHK("frame_bits", 6'h20, frame_bits)
		// Table loop: frame length, expiry moment, flag-only action
		for (int i = 0; i < 5; i++) begin
			flag_clear = 1'b1;
			tick(1);
			flag_clear = 1'b0;
			tocc_host_inst.cfg(rows[i][21:6]);
			`CHK("frame_bits", rows[i][5:0], frame_bits)
			`CHK("crc_active", rows[i][6], crc_active)
			n = rows[i][8] ? (rows[i][13:10] + 1) * 10 : 20;
			tick(n - 3);
			`CHK("flag_early", 1'b0, expiry_flag)
			tick(6);
			`CHK("flag_late", rows[i][8], expiry_flag)
			`CHK("int_n", ~rows[i][8], int_n)
			`CHK("cfg_kept", rows[i][21:6], cfg_q)
		end
		// Transactions keep restarting the watch
		flag_clear = 1'b1;
		tocc_host_inst.cfg(16'h0004);
		flag_clear = 1'b0;
		repeat (5) begin
			tick(5);
			tocc_host_inst.xact();
		end
		`CHK("flag_held", 1'b0, expiry_flag)
		// Automatic overload retry on channel 0
		tocc_host_inst.cfg(16'h0001);
		tocc_host_inst.pwr(16'h000F);
		overload_in = 4'h1;
		tick(5);
		`CHK("amp_off", 1'b0, amp_on[0])
		`CHK("ovl_flag", 1'b1, overload_flag[0])
		cnt = 0;
		repeat (80) begin
			tick(1);
			cnt += amp_on[0];
		end
		`CHK("retry_on", 8, cnt)
		overload_in = 4'h0;
		// Amplifier stays off until the next retry window sees the overload gone
		tick(40);
		cnt = 0;
		repeat (40) begin
			tick(1);
			cnt += amp_on[0];
		end
		`CHK("stay_on", 40, cnt)
		// Host-controlled overload on channel 1
		tocc_host_inst.cfg(16'h0003);
		overload_in = 4'h2;
		tick(3);
		`CHK("pwr_clr", 4'hD, channel_power_bits)
		`CHK("amp1_off", 1'b0, amp_on[1])
		`CHK("ovl1_flag", 1'b1, overload_flag[1])
		overload_in = 4'h0;
		tick(50);
		`CHK("no_restart", 1'b0, amp_on[1])
		tocc_host_inst.pwr(16'h000F);
		tick(2);
		`CHK("restart", 1'b1, amp_on[1])
		// Expiry with reset action keeps frame check and reference bits
		tocc_host_inst.cfg(16'h010C);
		cnt = 0;
		repeat (15) begin
			tick(1);
			cnt += soft_reset;
		end
		`CHK("soft_reset", 1, cnt)
		`CHK("cfg_after", 16'h0100, cfg_q)
		`CHK("flag_kept", 1'b1, expiry_flag)
		`CHK("pwr_after", 4'h0, channel_power_bits)
		`CHK("ovl_after", 4'h0, overload_flag)
		flag_enable = 1'b0;
		tick(1);
		`CHK("int_masked", 1'b1, int_n)
		// Writes ignored while frozen
		clk_en = 1'b0;
		tocc_host_inst.cfg(16'h0000);
		clk_en = 1'b1;
		`CHK("frozen", 16'h0100, cfg_q)
		// Reset in mid-run brings the defaults back
		rst = 1'b1;
		tick(1);
		rst = 1'b0;
		`CHK("cfg_rst", 16'h0001, cfg_q)
		`CHK("frame_rst", 6'h20, frame_bits)
		stop_test();
	end
endmodule
